// ---- logic/chc_ctrl_regs.v ----
// Charger control registers 0x11-0x13 behind an I2C target, with watchdog and ship FET delay
// Functional notes
// - Writing one to force_port_detect starts detection and the bit clears itself when done.
// - With auto_port_detect_on_plug set, VBUS arrival starts detection, otherwise it does not.
// - The 12 V request is allowed only while allow_twelve_volt_request is one, default zero.
// - The 9 V request is allowed only while allow_nine_volt_request is one, default zero.
// - The high-voltage handshake runs only while hv_port_handshake_on is one, reset zero.
// - shipfet_action_select means none, shutdown, ship mode or system power reset.
// - The ship FET action waits 10 s unless shipfet_action_no_delay is one.
// - block_input_gate_drivers forces both input gate driver bits to zero against writes.
// - forward_audio_skip_off defaults to zero and one disables out-of-audio in forward mode.
// - battery_switch_ldo_off defaults zero and clears on watchdog expiry and register reset.
// - Register 0x11 resets to 0x40.
// - Register 0x12 resets to zero, except that register reset keeps bit 7, with bits 6, 5 and 1 read-only.
// - Register 0x13 has a strap-loaded bit, bit 0 resets to one and bits 2 and 1 are read-only.
// - switching_rate_select loads from the strap, zero for 1.5 MHz and one for 750 kHz.
// - While shipfet_fitted is zero the action field is held at zero and writes are ignored.
// - The watchdog timeout decodes off, 0.5, 1, 2, 20, 40, 80, 160 s and expiry resets fields.
`timescale 1ns/1ps
`include "chc_defines.vh"
module chc_ctrl_regs #(
   parameter [13:0] MS_CYCLES   = `CHC_MS_CYCLES,   // Clock cycles per millisecond
   parameter [17:0] SHIP_DLY_MS = `CHC_SHIP_DLY_MS, // Ship FET action delay
   parameter [6:0]  I2C_ADDR    = `CHC_I2C_ADDR     // Target address, arbitrary value
) (
   input  wire       clk,                    // System clock, 10 MHz
   input  wire       arst_n,                 // Async reset, active low
   input  wire       scl_in,                 // I2C clock pin
   input  wire       sda_in,                 // I2C data pin level
   output reg        sda_out,                // I2C data drive value, always low
   output reg        sda_oe,                 // I2C data pull-low enable
   input  wire       vbus_present,           // VBUS present, asynchronous
   input  wire       strap_rate,             // Switching rate strap pin
   input  wire       detect_done,            // Detection finished pulse
   input  wire       shipfet_fitted,         // Ship FET populated
   input  wire       reg_reset,              // Register reset pulse
   input  wire [2:0] wd_timeout_sel,         // Watchdog timeout code
   input  wire       wd_restart,             // Watchdog restart pulse
   output reg        port_detect_start,      // Start detection pulse
   output reg        port_detect_busy,       // force_port_detect state
   output reg        hv_handshake_run,       // High-voltage handshake allowed
   output reg        nine_volt_ok,           // 9 V request allowed
   output reg        twelve_volt_ok,         // 12 V request allowed
   output reg        shipfet_go,             // Ship FET action pulse
   output reg  [1:0] shipfet_action,         // Action taken with shipfet_go
   output reg        input1_gate_driver_on,  // Input 1 gate driver
   output reg        input2_gate_driver_on,  // Input 2 gate driver
   output reg        battery_switch_ldo_off, // Battery switch LDO off
   output reg        forward_audio_skip_off, // Out-of-audio off in forward mode
   output reg        switching_rate_select,  // 0 = 1.5 MHz, 1 = 750 kHz
   output reg        wd_expired              // Watchdog expiry pulse
);
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_ADDR = 3'h1;
   localparam [2:0] S_AACK = 3'h2;
   localparam [2:0] S_WR   = 3'h3;
   localparam [2:0] S_WACK = 3'h4;
   localparam [2:0] S_RD   = 3'h5;
   localparam [2:0] S_RACK = 3'h6;

   reg  [7:0]  reg_det;
   reg  [7:0]  reg_opt;
   reg  [7:0]  reg_rate;
   reg  [7:0]  next_det;
   reg  [7:0]  next_opt;
   reg  [7:0]  next_rate;
   reg  [1:0]  scl_m;
   reg  [1:0]  sda_m;
   reg  [1:0]  vbus_m;
   reg  [1:0]  strap_m;
   reg         scl_d;
   reg         sda_d;
   reg         vbus_d;
   reg  [1:0]  strap_wait;
   reg         strap_take;
   reg  [2:0]  state;
   reg  [3:0]  bitcnt;
   reg  [7:0]  shreg;
   reg  [7:0]  ptr;
   reg         ptr_phase;
   reg         rw;
   reg         nack;
   reg         wr_en;
   reg  [7:0]  wr_addr;
   reg  [7:0]  wr_data;
   reg  [7:0]  rdata;
   reg  [13:0] ms_cnt;
   reg         ms_tick;
   reg  [2:0]  wd_sel_q;
   reg  [17:0] wd_load;
   reg         ship_start;
   reg  [17:0] ship_load;
   wire        wd_done;
   wire        ship_done;
   wire        scl_s   = scl_m[1];
   wire        sda_s   = sda_m[1];
   wire        i2c_start = scl_s && scl_d && sda_d && !sda_s;
   wire        i2c_stop  = scl_s && scl_d && !sda_d && sda_s;
   wire        scl_rise  = scl_s && !scl_d;
   wire        scl_fall  = !scl_s && scl_d;
   wire        wr_det  = wr_en && (wr_addr == `CHC_OFS_DET);
   wire        wr_opt  = wr_en && (wr_addr == `CHC_OFS_OPT);
   wire        wr_rate = wr_en && (wr_addr == `CHC_OFS_RATE);
   wire        wd_start = wr_en | wd_restart | wd_done | (wd_sel_q != wd_timeout_sel);

   // Pin synchronisers, second stage feeds all logic
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_m   <= 2'h3;
         sda_m   <= 2'h3;
         vbus_m  <= 2'h0;
         strap_m <= 2'h0;
         scl_d   <= 1'b1;
         sda_d   <= 1'b1;
         vbus_d  <= 1'b0;
      end else begin
         scl_m   <= {scl_m[0], scl_in};
         sda_m   <= {sda_m[0], sda_in};
         vbus_m  <= {vbus_m[0], vbus_present};
         strap_m <= {strap_m[0], strap_rate};
         scl_d   <= scl_m[1];
         sda_d   <= sda_m[1];
         vbus_d  <= vbus_m[1];
      end
   end

   // Strap is sampled once the synchroniser holds valid data
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         strap_wait <= 2'h0;
         strap_take <= 1'b0;
      end else begin
         strap_take <= 1'b0;
         if (strap_wait != `CHC_STRAP_WAIT) begin
            strap_wait <= strap_wait + 2'h1;
            strap_take <= (strap_wait + 2'h1 == `CHC_STRAP_WAIT);
         end
      end
   end

   always @* begin
      case (ptr)
         `CHC_OFS_DET:  rdata = reg_det;
         `CHC_OFS_OPT:  rdata = reg_opt;
         `CHC_OFS_RATE: rdata = reg_rate;
         default:       rdata = 8'h00;
      endcase
   end

   // I2C target: pointer byte, then auto-incrementing data bytes
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state     <= S_IDLE;
         bitcnt    <= 4'h0;
         shreg     <= 8'h00;
         ptr       <= 8'h00;
         ptr_phase <= 1'b0;
         rw        <= 1'b0;
         nack      <= 1'b0;
         sda_out   <= 1'b0;
         sda_oe    <= 1'b0;
         wr_en     <= 1'b0;
         wr_addr   <= 8'h00;
         wr_data   <= 8'h00;
      end else begin
         wr_en <= 1'b0;
         if (i2c_start) begin
            state  <= S_ADDR;
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
         end else if (i2c_stop) begin
            state  <= S_IDLE;
            sda_oe <= 1'b0;
         end else if (scl_rise) begin
            if (state == S_ADDR || state == S_WR) begin
               shreg  <= {shreg[6:0], sda_s};
               bitcnt <= bitcnt + 4'h1;
            end else if (state == S_RACK) begin
               nack <= sda_s;
            end
         end else if (scl_fall) begin
            case (state)
               S_ADDR: begin
                  if (bitcnt == 4'h8) begin
                     if (shreg[7:1] == I2C_ADDR) begin
                        state  <= S_AACK;
                        sda_oe <= 1'b1;
                        rw     <= shreg[0];
                     end else begin
                        state <= S_IDLE;
                     end
                  end
               end
               S_AACK: begin
                  bitcnt <= 4'h0;
                  if (rw) begin
                     state  <= S_RD;
                     shreg  <= rdata;
                     sda_oe <= ~rdata[7];
                     ptr    <= ptr + 8'h01;
                  end else begin
                     state     <= S_WR;
                     sda_oe    <= 1'b0;
                     ptr_phase <= 1'b1;
                  end
               end
               S_WR: begin
                  if (bitcnt == 4'h8) begin
                     state  <= S_WACK;
                     sda_oe <= 1'b1;
                     if (ptr_phase) begin
                        ptr <= shreg;
                     end else begin
                        wr_en   <= 1'b1;
                        wr_addr <= ptr;
                        wr_data <= shreg;
                        ptr     <= ptr + 8'h01;
                     end
                  end
               end
               S_WACK: begin
                  state     <= S_WR;
                  sda_oe    <= 1'b0;
                  ptr_phase <= 1'b0;
                  bitcnt    <= 4'h0;
               end
               S_RD: begin
                  if (bitcnt == 4'h7) begin
                     state  <= S_RACK;
                     sda_oe <= 1'b0;
                  end else begin
                     shreg  <= {shreg[6:0], 1'b0};
                     sda_oe <= ~shreg[6];
                     bitcnt <= bitcnt + 4'h1;
                  end
               end
               S_RACK: begin
                  if (nack) begin
                     state <= S_IDLE;
                  end else begin
                     state  <= S_RD;
                     bitcnt <= 4'h0;
                     shreg  <= rdata;
                     sda_oe <= ~rdata[7];
                     ptr    <= ptr + 8'h01;
                  end
               end
               default: state <= S_IDLE;
            endcase
         end
      end
   end

   // Register next values; a write wins over a clear in the same cycle
   always @* begin
      next_det  = reg_det;
      next_opt  = reg_opt;
      next_rate = reg_rate;
      if (reg_reset) begin
         next_det  = `CHC_RST_DET;
         next_opt  = (reg_opt & 8'h80) | `CHC_RST_OPT;
         next_rate = (reg_rate & 8'he4) | `CHC_RST_RATE;
      end else if (wd_done) begin
         next_det[`CHC_B_FORCE] = 1'b0;
         next_det[`CHC_B_AUTO]  = 1'b1;
         next_opt[`CHC_B_LDO]   = 1'b0;
         next_rate[`CHC_B_STAT] = 1'b0;
      end
      if (detect_done) begin
         next_det[`CHC_B_FORCE] = 1'b0;
      end
      if (wr_det) begin
         next_det = wr_data & `CHC_WMASK_DET;
      end
      // read-only bits of 0x12 stay zero
      if (wr_opt) begin
         next_opt = wr_data & `CHC_WMASK_OPT;
      end
      // bits 2 and 1 of 0x13 cannot be written
      if (wr_rate) begin
         next_rate = wr_data & `CHC_WMASK_RATE;
      end
      if (strap_take) begin
         next_rate[`CHC_B_RATE] = strap_m[1];
      end
      if (!shipfet_fitted) begin
         next_det[`CHC_B_ACT_HI:`CHC_B_ACT_LO] = `CHC_ACT_NONE;
      end
      if (next_opt[`CHC_B_BLOCK]) begin
         next_rate[`CHC_B_GD2] = 1'b0;
         next_rate[`CHC_B_GD1] = 1'b0;
      end
   end

   always @* begin
      case (wd_timeout_sel)
         3'h1:    wd_load = `CHC_WD_T1_MS;
         3'h2:    wd_load = `CHC_WD_T2_MS;
         3'h3:    wd_load = `CHC_WD_T3_MS;
         3'h4:    wd_load = `CHC_WD_T4_MS;
         3'h5:    wd_load = `CHC_WD_T5_MS;
         3'h6:    wd_load = `CHC_WD_T6_MS;
         3'h7:    wd_load = `CHC_WD_T7_MS;
         default: wd_load = 18'h00000;
      endcase
   end

   // delay applied unless skipped; any write to 0x11 restarts or cancels it
   always @* begin
      ship_start = 1'b0;
      ship_load  = 18'h00000;
      if (wr_det) begin
         ship_start = 1'b1;
         if (next_det[`CHC_B_ACT_HI:`CHC_B_ACT_LO] != `CHC_ACT_NONE
             && !next_det[`CHC_B_NODLY]) begin
            ship_load = SHIP_DLY_MS;
         end
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ms_cnt  <= 14'h0000;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= (ms_cnt == MS_CYCLES - 14'h0001);
         if (ms_cnt == MS_CYCLES - 14'h0001) begin
            ms_cnt <= 14'h0000;
         end else begin
            ms_cnt <= ms_cnt + 14'h0001;
         end
      end
   end

   chc_timer #(.W(18)) u_wd_timer (
      .clk    (clk),
      .arst_n (arst_n),
      .start  (wd_start),
      .load   (wd_load),
      .tick   (ms_tick),
      .done   (wd_done),
      .busy   ()
   );

   chc_timer #(.W(18)) u_ship_timer (
      .clk    (clk),
      .arst_n (arst_n),
      .start  (ship_start),
      .load   (ship_load),
      .tick   (ms_tick),
      .done   (ship_done),
      .busy   ()
   );

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_det                <= `CHC_RST_DET;
         reg_opt                <= `CHC_RST_OPT;
         reg_rate               <= `CHC_RST_RATE;
         wd_sel_q               <= `CHC_WD_SEL_RST;
         port_detect_start      <= 1'b0;
         port_detect_busy       <= 1'b0;
         hv_handshake_run       <= 1'b0;
         nine_volt_ok           <= 1'b0;
         twelve_volt_ok         <= 1'b0;
         shipfet_go             <= 1'b0;
         shipfet_action         <= `CHC_ACT_NONE;
         input1_gate_driver_on  <= 1'b0;
         input2_gate_driver_on  <= 1'b0;
         battery_switch_ldo_off <= 1'b0;
         forward_audio_skip_off <= 1'b0;
         switching_rate_select  <= 1'b0;
         wd_expired             <= 1'b0;
      end else begin
         reg_det  <= next_det;
         reg_opt  <= next_opt;
         reg_rate <= next_rate;
         wd_sel_q <= wd_timeout_sel;
         port_detect_start <= (wr_det && wr_data[`CHC_B_FORCE])
                              || (reg_det[`CHC_B_AUTO] && vbus_m[1] && !vbus_d);
         port_detect_busy  <= next_det[`CHC_B_FORCE];
         hv_handshake_run  <= next_det[`CHC_B_HV];
         nine_volt_ok      <= next_det[`CHC_B_HV] && next_det[`CHC_B_9V];
         twelve_volt_ok    <= next_det[`CHC_B_HV] && next_det[`CHC_B_12V];
         // action fired now or after the delay
         shipfet_go <= 1'b0;
         if ((ship_start && ship_load == 18'h00000
              && next_det[`CHC_B_ACT_HI:`CHC_B_ACT_LO] != `CHC_ACT_NONE)
             || (ship_done && !ship_start
                 && next_det[`CHC_B_ACT_HI:`CHC_B_ACT_LO] != `CHC_ACT_NONE)) begin
            shipfet_go     <= 1'b1;
            shipfet_action <= next_det[`CHC_B_ACT_HI:`CHC_B_ACT_LO];
         end
         input1_gate_driver_on  <= next_rate[`CHC_B_GD1];
         input2_gate_driver_on  <= next_rate[`CHC_B_GD2];
         battery_switch_ldo_off <= next_opt[`CHC_B_LDO];
         forward_audio_skip_off <= next_opt[`CHC_B_OOA];
         switching_rate_select  <= next_rate[`CHC_B_RATE];
         wd_expired             <= wd_done;
      end
   end
endmodule

// ---- logic/chc_defines.vh ----
// Offsets, field positions, reset values and timing constants of the charger control bank
`ifndef CHC_DEFINES_VH
`define CHC_DEFINES_VH
`define CHC_OFS_DET      8'h11
`define CHC_OFS_OPT      8'h12
`define CHC_OFS_RATE     8'h13
`define CHC_RST_DET      8'h40
`define CHC_RST_OPT      8'h00
`define CHC_RST_RATE     8'h01
`define CHC_WMASK_DET    8'hff
`define CHC_WMASK_OPT    8'h9d
`define CHC_WMASK_RATE   8'hf9
`define CHC_B_FORCE      7
`define CHC_B_AUTO       6
`define CHC_B_12V        5
`define CHC_B_9V         4
`define CHC_B_HV         3
`define CHC_B_ACT_HI     2
`define CHC_B_ACT_LO     1
`define CHC_B_NODLY      0
`define CHC_B_BLOCK      7
`define CHC_B_PFM        4
`define CHC_B_WAKE       3
`define CHC_B_LDO        2
`define CHC_B_OOA        0
`define CHC_B_GD2        7
`define CHC_B_GD1        6
`define CHC_B_RATE       5
`define CHC_B_STAT       4
`define CHC_B_VSYS       3
`define CHC_B_OCP        0
`define CHC_ACT_NONE     2'h0
`define CHC_ACT_SHUTDOWN 2'h1
`define CHC_ACT_SHIP     2'h2
`define CHC_ACT_PWR_RST  2'h3
`define CHC_I2C_ADDR     7'h2a
`define CHC_CLK_HZ       10000000
`define CHC_MS_CYCLES    14'h2710
`define CHC_SHIP_DLY_S   10
`define CHC_SHIP_DLY_MS  18'h02710
`define CHC_WD_T1_MS     18'h001f4
`define CHC_WD_T2_MS     18'h003e8
`define CHC_WD_T3_MS     18'h007d0
`define CHC_WD_T4_MS     18'h04e20
`define CHC_WD_T5_MS     18'h09c40
`define CHC_WD_T6_MS     18'h13880
`define CHC_WD_T7_MS     18'h27100
`define CHC_WD_SEL_RST   3'h5
`define CHC_STRAP_WAIT   2'h2
`endif

// ---- logic/chc_timer.v ----
// Millisecond down-counter with restart and a one-cycle expiry pulse
`timescale 1ns/1ps
module chc_timer #(
   parameter W = 18
) (
   input  wire         clk,    // System clock
   input  wire         arst_n, // Async reset, active low
   input  wire         start,  // Load count; zero load stops the timer
   input  wire [W-1:0] load,   // Count in ticks
   input  wire         tick,   // One-cycle tick
   output reg          done,   // Expiry pulse
   output reg          busy    // Counting
);
   reg [W-1:0] cnt;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt  <= {W{1'b0}};
         done <= 1'b0;
         busy <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt  <= load;
            busy <= (load != {W{1'b0}});
         end else if (tick && busy) begin
            cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
            if (cnt == {{(W-1){1'b0}}, 1'b1}) begin
               done <= 1'b1;
               busy <= 1'b0;
            end
         end
      end
   end
endmodule

// ---- verif/chc_ctrl_regs_checker.sv ----
// Port-level assertions for the charger control register bank
`timescale 1ns/1ps
module chc_ctrl_regs_checker #(
   parameter [13:0] MS_CYCLES   = 14'd4, // Clock cycles per millisecond
   parameter [17:0] SHIP_DLY_MS = 18'd3  // Ship FET action delay
) (
   input wire       clk,                    // System clock
   input wire       arst_n,                 // Async reset, active low
   input wire       strap_rate,             // Rate strap
   input wire       detect_done,            // Detection finished
   input wire       shipfet_fitted,         // Ship FET populated
   input wire [2:0] wd_timeout_sel,         // Watchdog code
   input wire       port_detect_start,      // Detection start
   input wire       port_detect_busy,       // Forced detection bit
   input wire       hv_handshake_run,       // Handshake allowed
   input wire       nine_volt_ok,           // 9 V allowed
   input wire       twelve_volt_ok,         // 12 V allowed
   input wire       shipfet_go,             // Ship FET action
   input wire [1:0] shipfet_action,         // Action code
   input wire       battery_switch_ldo_off, // LDO off
   input wire       switching_rate_select,  // Rate select
   input wire       wd_expired              // Watchdog expiry
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_nine_needs_hv: assert property (nine_volt_ok |-> hv_handshake_run)
      else $error("9 V permitted without handshake");
   a_twelve_needs_hv: assert property (twelve_volt_ok |-> hv_handshake_run)
      else $error("12 V permitted without handshake");
   a_rate_from_strap: assert property ($rose(arst_n) |-> ##6 switching_rate_select == strap_rate)
      else $error("rate select not loaded from strap");
   a_wd_needs_code: assert property (wd_expired |-> $past(wd_timeout_sel) != 3'h0)
      else $error("watchdog expired while disabled");
   a_busy_starts: assert property ($rose(port_detect_busy) |-> ##[0:2] port_detect_start)
      else $error("forced detection did not start");
   a_done_clears: assert property (detect_done |-> ##[1:2] !port_detect_busy)
      else $error("force bit not cleared after detection");
   a_start_pulse: assert property (port_detect_start |=> !port_detect_start)
      else $error("detection start longer than one cycle");
   a_go_action: assert property (shipfet_go |-> shipfet_action != 2'h0)
      else $error("ship FET action with idle code");
   a_go_fitted: assert property (shipfet_go |-> shipfet_fitted)
      else $error("ship FET action without ship FET");
   a_wd_ldo_on: assert property (wd_expired |-> ##[1:3] !battery_switch_ldo_off)
      else $error("LDO off kept after watchdog expiry");
   c_ship: cover property (shipfet_go);
   c_wd: cover property (wd_expired);
   c_plug: cover property (port_detect_start && !port_detect_busy);
endmodule

bind chc_ctrl_regs chc_ctrl_regs_checker #(.MS_CYCLES(MS_CYCLES), .SHIP_DLY_MS(SHIP_DLY_MS)) u_chk (
   .clk(clk), .arst_n(arst_n), .strap_rate(strap_rate), .detect_done(detect_done),
   .shipfet_fitted(shipfet_fitted), .wd_timeout_sel(wd_timeout_sel),
   .port_detect_start(port_detect_start), .port_detect_busy(port_detect_busy),
   .hv_handshake_run(hv_handshake_run), .nine_volt_ok(nine_volt_ok),
   .twelve_volt_ok(twelve_volt_ok), .shipfet_go(shipfet_go), .shipfet_action(shipfet_action),
   .battery_switch_ldo_off(battery_switch_ldo_off),
   .switching_rate_select(switching_rate_select), .wd_expired(wd_expired));

// ---- verif/chc_i2c_host.sv ----
// I2C host model at 500 kHz for the charger control bank
`timescale 1ns/1ps
module chc_i2c_host (
   input  wire clk,  // Bench clock
   input  wire sda,  // Resolved data wire, pulled up
   output reg  scl,  // Serial clock, idle high
   output reg  pull  // Host pulls data low
);
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   task automatic hw(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Start or repeated start: data falls while clock high
   task automatic start;
      pull = 1'b0;
      hw(10);
      scl = 1'b1;
      hw(10);
      pull = 1'b1;
      hw(10);
      scl = 1'b0;
   endtask
   task automatic xbit(input logic b, output logic r);
      hw(2);
      pull = ~b;
      hw(8);
      scl = 1'b1;
      hw(10);
      r = sda;
      scl = 1'b0;
   endtask
   // Byte MSB first, then the acknowledge bit given by ackbit
   task automatic xbyte(input logic [7:0] d, input logic ackbit, output logic [7:0] q,
                        output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xbit(d[i], r);
         q[i] = r;
      end
      xbit(ackbit, r);
      ack = ~r;
   endtask
   task automatic stop;
      hw(2);
      pull = 1'b1;
      hw(8);
      scl = 1'b1;
      hw(10);
      pull = 1'b0;
      hw(10);
   endtask
endmodule

// ---- verif/tb_chc_ctrl_regs.sv ----
// Self-checking bench for the charger control register bank
`timescale 1ns/1ps
`include "chc_defines.vh"
module tb_chc_ctrl_regs;
   logic       clk = 1'b0, arst_n = 1'b0, vbus_present = 1'b0, strap_rate, detect_done = 1'b0;
   logic       shipfet_fitted = 1'b0, reg_reset = 1'b0, wd_restart = 1'b0;
   logic [2:0] wd_timeout_sel = 3'h0;
   wire        sda, scl, pull, sda_out, sda_oe, pds, pdb, hv, v9, v12, go, gd1, gd2, ldo, ooa;
   wire        rate, wde;
   wire  [1:0] act;
   int         failures = 0, samples_checked = 0, go_n = 0, det_n = 0, wd_n = 0, go_mid;
   logic [1:0] go_act;
   assign sda = ~(pull | sda_oe);
   always #50 clk = ~clk;
   chc_i2c_host host (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
   chc_ctrl_regs #(.MS_CYCLES(14'd4), .SHIP_DLY_MS(18'd10)) dut (
      .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .vbus_present(vbus_present), .strap_rate(strap_rate),
      .detect_done(detect_done), .shipfet_fitted(shipfet_fitted), .reg_reset(reg_reset),
      .wd_timeout_sel(wd_timeout_sel), .wd_restart(wd_restart), .port_detect_start(pds),
      .port_detect_busy(pdb), .hv_handshake_run(hv), .nine_volt_ok(v9), .twelve_volt_ok(v12),
      .shipfet_go(go), .shipfet_action(act), .input1_gate_driver_on(gd1),
      .input2_gate_driver_on(gd2), .battery_switch_ldo_off(ldo),
      .forward_audio_skip_off(ooa), .switching_rate_select(rate), .wd_expired(wde));
   always @(posedge clk) begin
      if (go === 1'b1) begin
         go_n++;
         go_act = act;
      end
      if (pds === 1'b1) det_n++;
      if (wde === 1'b1) wd_n++;
   end
   task automatic final_report;
      if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wait_for(input bit w, input int base, input int lim);
      for (int i = 0; i < lim && (w ? wd_n : go_n) == base; i++) @(negedge clk);
      if ((w ? wd_n : go_n) == base) begin
         failures++;
         final_report();
      end
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic [7:0] q;
      logic       a;
      host.start();
      host.xbyte({`CHC_I2C_ADDR, 1'b0}, 1'b1, q, a);
      chk("addr ack", 8'h01, {6'h0, sda_out, a});
      host.xbyte(p, 1'b1, q, a);
      host.xbyte(d, 1'b1, q, a);
      go_mid = go_n;
      host.stop();
   endtask
   task automatic rc(input logic [7:0] p, input logic [7:0] e);
      logic [7:0] d;
      logic       a;
      host.start();
      host.xbyte({`CHC_I2C_ADDR, 1'b0}, 1'b1, d, a);
      host.xbyte(p, 1'b1, d, a);
      host.start();
      host.xbyte({`CHC_I2C_ADDR, 1'b1}, 1'b1, d, a);
      host.xbyte(8'hff, 1'b1, d, a);
      host.stop();
      chk($sformatf("reg %h", p), e, d);
   endtask
   initial begin
      logic [7:0] v, q;
      logic       a;
      int         n;
      v = $urandom(58706);
      strap_rate = v[0];
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      repeat (6) @(negedge clk);
      rc(`CHC_OFS_DET, `CHC_RST_DET);
      rc(`CHC_OFS_OPT, `CHC_RST_OPT);
      rc(`CHC_OFS_RATE, {2'h0, strap_rate, 5'h01});
      chk("rate", {7'h0, strap_rate}, {7'h0, rate});
      rc(8'h14, 8'h00);
      host.start();
      host.xbyte({~`CHC_I2C_ADDR, 1'b0}, 1'b1, q, a);
      host.stop();
      chk("foreign ack", 8'h00, {7'h0, a});
      wr(`CHC_OFS_OPT, 8'hff);
      rc(`CHC_OFS_OPT, `CHC_WMASK_OPT);
      chk("ldo", 8'h01, {7'h0, ldo});
      chk("ooa", 8'h01, {7'h0, ooa});
      wr(`CHC_OFS_RATE, {2'h3, strap_rate, 5'h07});
      rc(`CHC_OFS_RATE, {2'h0, strap_rate, 5'h01});
      chk("gates", 8'h00, {6'h0, gd2, gd1});
      reg_reset = 1'b1;
      @(negedge clk);
      reg_reset = 1'b0;
      repeat (3) @(negedge clk);
      rc(`CHC_OFS_OPT, 8'h80);
      chk("ldo", 8'h00, {7'h0, ldo});
      wr(`CHC_OFS_OPT, 8'h00);
      v = $urandom;
      wr(`CHC_OFS_RATE, v);
      rc(`CHC_OFS_RATE, v & `CHC_WMASK_RATE);
      chk("gates", {6'h0, v[7:6]}, {6'h0, gd2, gd1});
      chk("rate", {7'h0, v[5]}, {7'h0, rate});
      for (int i = 0; i < 8; i++) begin
         v = {2'h1, i[2:0], 3'h0};
         wr(`CHC_OFS_DET, v);
         rc(`CHC_OFS_DET, v);
         chk("hv", {7'h0, v[3]}, {7'h0, hv});
         chk("v9", {7'h0, v[3] & v[4]}, {7'h0, v9});
         chk("v12", {7'h0, v[3] & v[5]}, {7'h0, v12});
      end
      n = det_n;
      wr(`CHC_OFS_DET, 8'h80);
      chk("det", 8'h01, 8'(det_n - n));
      chk("busy", 8'h01, {7'h0, pdb});
      detect_done = 1'b1;
      @(negedge clk);
      detect_done = 1'b0;
      repeat (3) @(negedge clk);
      chk("busy", 8'h00, {7'h0, pdb});
      rc(`CHC_OFS_DET, 8'h00);
      for (int k = 0; k < 2; k++) begin
         wr(`CHC_OFS_DET, {1'b0, k[0], 6'h0});
         n = det_n;
         vbus_present = 1'b1;
         repeat (12) @(negedge clk);
         chk("plug det", {7'h0, k[0]}, 8'(det_n - n));
         vbus_present = 1'b0;
         repeat (6) @(negedge clk);
      end
      n = go_n;
      wr(`CHC_OFS_DET, 8'h45);
      rc(`CHC_OFS_DET, 8'h41);
      chk("go", 8'h00, 8'(go_n - n));
      shipfet_fitted = 1'b1;
      for (int k = 1; k < 4; k++) begin
         n = go_n;
         wr(`CHC_OFS_DET, {5'h0, k[1:0], 1'b1});
         chk("go", 8'h01, 8'(go_n - n));
         chk("act", {6'h0, k[1:0]}, {6'h0, go_act});
      end
      n = go_n;
      wr(`CHC_OFS_DET, 8'h04);
      chk("early go", 8'h00, 8'(go_mid - n));
      wait_for(1'b0, n, 100);
      chk("act", {6'h0, `CHC_ACT_SHIP}, {6'h0, go_act});
      wr(`CHC_OFS_DET, 8'h00);
      wr(`CHC_OFS_OPT, 8'h04);
      chk("ldo", 8'h01, {7'h0, ldo});
      n = wd_n;
      wd_timeout_sel = 3'h1;
      wait_for(1'b1, n, 2500);
      wd_timeout_sel = 3'h0;
      repeat (3) @(negedge clk);
      chk("ldo", 8'h00, {7'h0, ldo});
      rc(`CHC_OFS_DET, 8'h40);
      final_report();
   end
endmodule
